// ===== hw/dspm_consts.svh
// Register offsets, field positions and reset values of the fractional MAC datapath
`ifndef DSPM_CONSTS_SVH
`define DSPM_CONSTS_SVH
`define DSPM_ADDR_W 8
`define DSPM_OFF_OPA 8'h00
`define DSPM_OFF_OPB 8'h04
`define DSPM_OFF_CTRL 8'h08
`define DSPM_OFF_CMD 8'h0C
`define DSPM_OFF_RESULT 8'h10
`define DSPM_ACC_BASE_HI 3'h1
`define DSPM_CTRL_MASK 32'h0F1F7C00
`define DSPM_CTRL_RST 32'h00000000
`define DSPM_CCOND_LSB 24
`define DSPM_SIZE_LSB 10
`define DSPM_POS_LSB 16
`define DSPM_CMD_OP_LSB 0
`define DSPM_CMD_ACC_LSB 8
`define DSPM_CMD_ARG_LSB 16
`define DSPM_RESP_OKAY 2'h0
`define DSPM_RESP_SLVERR 2'h2
`endif

// ===== hw/dspm_pkg.sv
// Types shared by the fractional MAC datapath
package dspm_pkg;
  typedef logic [31:0] dspm_word_t;
  typedef logic [63:0] dspm_acc_t;
  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_DOT_ADD = 6'h01, OP_DOT_SUB = 6'h02, OP_CPLX_STEP = 6'h03,
    OP_Q31_ADD = 6'h04, OP_Q31_SUB = 6'h05, OP_MAC_L = 6'h06, OP_MAC_R = 6'h07,
    OP_MAC_SAT_L = 6'h08, OP_MAC_SAT_R = 6'h09, OP_MULT = 6'h0A, OP_MULTU = 6'h0B,
    OP_MADD = 6'h0C, OP_MADDU = 6'h0D, OP_MSUB = 6'h0E, OP_MSUBU = 6'h0F,
    OP_BIT_REV = 6'h10, OP_FIELD_INS = 6'h11, OP_REPB_IMM = 6'h12, OP_REPB_REG = 6'h13,
    OP_REPH_IMM = 6'h14, OP_REPH_REG = 6'h15, OP_CMPB_EQ = 6'h16, OP_CMPB_LT = 6'h17,
    OP_CMPB_LE = 6'h18, OP_CMPG_EQ = 6'h19, OP_CMPG_LT = 6'h1A, OP_CMPG_LE = 6'h1B,
    OP_CMPH_EQ = 6'h1C, OP_CMPH_LT = 6'h1D, OP_CMPH_LE = 6'h1E, OP_SELB = 6'h1F,
    OP_SELH = 6'h20, OP_PACK = 6'h21, OP_XW = 6'h22, OP_XW_RND = 6'h23,
    OP_XW_RSAT = 6'h24, OP_XH_SAT = 6'h25
  } dspm_op_e;
endpackage

// ===== hw/dspm_datapath.sv
// Fractional MAC and SIMD datapath behind an AXI4-Lite register slave
// What this block does
// - Dual Q15 dot add: shift products, clamp -1 squared, sum, add to accumulator
// - Dual Q15 dot subtract: same clamped product sum subtracted from accumulator
// - Complex step: clamped Q15 products, difference added to accumulator
// - Q31 multiply add: clamped Q63 product added, accumulator saturates at 64 bits
// - Q31 multiply subtract: clamped Q63 product subtracted, accumulator saturates
// - Single Q15 MAC on left or right halves, clamped, sign-extended, added
// - Saturating single Q15 MAC clamps accumulator into Q31 range
// - Integer multiply, multiply-add and multiply-subtract target any accumulator
// - Bit reverse of low 16 bits, upper 16 result bits zero
// - Field insert with size from control bits 14:10, position from 20:16
// - Byte replicate from low 8 bits of immediate or register
// - Halfword replicate from low register half or sign-extended 10-bit immediate
// - Unsigned byte-lane compare writes four low condition bits
// - Unsigned byte-lane compare writes four low result bits
// - Signed halfword compare writes two low condition bits
// - Byte select per lane: first source when condition bit is one
// - Halfword select per lane: first source when condition bit is one
// - Word extract: logical shift 0..31, optional rounding, optional overflow clamp
// - Half extract: logical shift 0..31, always saturated to Q15 range
`timescale 1ns/1ns
`include "dspm_consts.svh"
module dspm_datapath (
  // Clock, reset, enable
  input wire logic MCLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  // Write address and data
  input wire logic [`DSPM_ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire dspm_pkg::dspm_word_t S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // Write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // Read address and data
  input wire logic [`DSPM_ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output dspm_pkg::dspm_word_t S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);
  import dspm_pkg::*;

  // Clamped Q15 product shifted to Q31
  function automatic dspm_word_t q15_prod(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    if (a == 16'h8000 && b == 16'h8000) begin
      q15_prod = 32'h7FFFFFFF;
    end else begin
      q15_prod = {p[30:0], 1'b0};
    end
  endfunction

  // Clamped Q31 product shifted to Q63
  function automatic dspm_acc_t q31_prod(input dspm_word_t a, input dspm_word_t b);
    logic signed [63:0] p;
    p = $signed(a) * $signed(b);
    if (a == 32'h80000000 && b == 32'h80000000) begin
      q31_prod = 64'h7FFFFFFFFFFFFFFF;
    end else begin
      q31_prod = {p[62:0], 1'b0};
    end
  endfunction

  // 64-bit add that saturates on overflow or underflow
  function automatic dspm_acc_t sat_add64(input dspm_acc_t a, input dspm_acc_t b);
    logic [64:0] s;
    s = {a[63], a} + {b[63], b};
    if (s[64] != s[63]) begin
      sat_add64 = s[64] ? 64'h8000000000000000 : 64'h7FFFFFFFFFFFFFFF;
    end else begin
      sat_add64 = s[63:0];
    end
  endfunction

  // Sign-extend a 33-bit sum to accumulator width
  function automatic dspm_acc_t sext33(input logic [32:0] v);
    sext33 = {{31{v[32]}}, v};
  endfunction

  // Merge write data under byte strobes
  function automatic dspm_word_t apply_strb(input dspm_word_t old, input dspm_word_t nw,
                                            input logic [3:0] strb);
    dspm_word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    apply_strb = r;
  endfunction

  // Reset release through two flops
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Architectural and bus state
  dspm_word_t opa_q, opa_d, opb_q, opb_d, ctrl_q, ctrl_d, result_q, result_d;
  dspm_word_t acc_hi_q [4];
  dspm_word_t acc_hi_d [4];
  dspm_word_t acc_lo_q [4];
  dspm_word_t acc_lo_d [4];
  logic aw_full_q, aw_full_d, w_full_q, w_full_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [`DSPM_ADDR_W-1:0] awaddr_q, awaddr_d;
  dspm_word_t wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

  // Handshakes stall while the enable is low
  assign S_AXI_AWREADY_O = CE_I && !aw_full_q;
  assign S_AXI_WREADY_O = CE_I && !w_full_q;
  assign S_AXI_ARREADY_O = CE_I && !rvalid_q;
  assign S_AXI_BVALID_O = bvalid_q;
  assign S_AXI_BRESP_O = bresp_q;
  assign S_AXI_RVALID_O = rvalid_q;
  assign S_AXI_RDATA_O = rdata_q;
  assign S_AXI_RRESP_O = rresp_q;

  // Write fires once both halves are held and the old response is gone
  logic wr_fire;
  logic exec;
  dspm_word_t cmd_word;
  dspm_op_e op;
  logic [1:0] acc_sel;
  logic [4:0] arg5;
  logic [9:0] imm10;
  assign wr_fire = CE_I && aw_full_q && w_full_q && !bvalid_q;
  assign cmd_word = apply_strb(32'h00000000, wdata_q, wstrb_q);
  assign exec = wr_fire && awaddr_q == `DSPM_OFF_CMD;
  assign op = dspm_op_e'(cmd_word[`DSPM_CMD_OP_LSB +: 6]);
  assign acc_sel = cmd_word[`DSPM_CMD_ACC_LSB +: 2];
  assign arg5 = cmd_word[`DSPM_CMD_ARG_LSB +: 5];
  assign imm10 = cmd_word[`DSPM_CMD_ARG_LSB +: 10];

  // Shared arithmetic terms
  dspm_acc_t acc_cur;
  dspm_word_t p_hi, p_lo, p_sel;
  logic [32:0] dot_sum, dot_dif;
  logic [3:0] ccond;
  logic [4:0] fsize, fpos;
  logic [64:0] xt, xr;
  dspm_acc_t xs;
  logic [32:0] fmask;
  assign acc_cur = {acc_hi_q[acc_sel], acc_lo_q[acc_sel]};
  assign p_hi = q15_prod(opa_q[31:16], opb_q[31:16]);
  assign p_lo = q15_prod(opa_q[15:0], opb_q[15:0]);
  assign p_sel = (op == OP_MAC_L || op == OP_MAC_SAT_L) ? p_hi : p_lo;
  assign dot_sum = {p_hi[31], p_hi} + {p_lo[31], p_lo};
  assign dot_dif = {p_hi[31], p_hi} - {p_lo[31], p_lo};
  assign ccond = ctrl_q[`DSPM_CCOND_LSB +: 4];
  assign fsize = ctrl_q[`DSPM_SIZE_LSB +: 5];
  assign fpos = ctrl_q[`DSPM_POS_LSB +: 5];
  // Extra low bit lets rounding add one at the top discarded position
  assign xt = {acc_cur, 1'b0} >> arg5;
  assign xr = xt + 65'h00000000000000001;
  assign xs = acc_cur >> arg5;
  assign fmask = ((33'h000000001 << fsize) - 33'h000000001) << fpos;
  // Full 64-bit products; a self-sized multiply would lose the high word
  dspm_acc_t mul_s, mul_u;
  assign mul_s = $signed(opa_q) * $signed(opb_q);
  assign mul_u = opa_q * opb_q;

  // Next-state logic for bus and datapath
  always_comb begin
    dspm_acc_t acc_new;
    dspm_word_t gpr;
    logic [64:0] s65;
    logic gpr_wr;
    logic acc_wr;
    acc_new = acc_cur;
    gpr = result_q;
    s65 = 65'h00000000000000000;
    gpr_wr = 1'b0;
    acc_wr = 1'b0;
    opa_d = opa_q;
    opb_d = opb_q;
    ctrl_d = ctrl_q;
    result_d = result_q;
    acc_hi_d = acc_hi_q;
    acc_lo_d = acc_lo_q;
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    // Capture address and data in either order
    if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_full_d = 1'b1;
      awaddr_d = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_full_d = 1'b1;
      wdata_d = S_AXI_WDATA_I;
      wstrb_d = S_AXI_WSTRB_I;
    end
    if (bvalid_q && S_AXI_BREADY_I) begin
      bvalid_d = 1'b0;
    end
    // Operation execution on a command write
    if (exec) begin
      case (op)
        OP_DOT_ADD: begin acc_new = acc_cur + sext33(dot_sum); acc_wr = 1'b1; end
        OP_DOT_SUB: begin acc_new = acc_cur - sext33(dot_sum); acc_wr = 1'b1; end
        OP_CPLX_STEP: begin acc_new = acc_cur + sext33(dot_dif); acc_wr = 1'b1; end
        OP_Q31_ADD: begin
          acc_new = sat_add64(acc_cur, q31_prod(opa_q, opb_q));
          acc_wr = 1'b1;
        end
        // saturating Q63 subtract, negation of min product cannot occur
        OP_Q31_SUB: begin
          acc_new = sat_add64(acc_cur, 64'h0000000000000000 - q31_prod(opa_q, opb_q));
          acc_wr = 1'b1;
        end
        OP_MAC_L, OP_MAC_R: begin
          acc_new = acc_cur + {{32{p_sel[31]}}, p_sel};
          acc_wr = 1'b1;
        end
        OP_MAC_SAT_L, OP_MAC_SAT_R: begin
          s65 = {acc_cur[63], acc_cur} + {{33{p_sel[31]}}, p_sel};
          if ($signed(s65) > $signed(65'h000000007FFFFFFFF >> 4)) begin
            acc_new = 64'h000000007FFFFFFF;
          end else if ($signed(s65) < $signed(65'h1FFFFFFFF80000000)) begin
            acc_new = 64'hFFFFFFFF80000000;
          end else begin
            acc_new = s65[63:0];
          end
          acc_wr = 1'b1;
        end
        OP_MULT: begin
          acc_new = mul_s;
          acc_wr = 1'b1;
        end
        OP_MULTU: begin
          acc_new = mul_u;
          acc_wr = 1'b1;
        end
        OP_MADD: begin
          acc_new = acc_cur + mul_s;
          acc_wr = 1'b1;
        end
        OP_MADDU: begin
          acc_new = acc_cur + mul_u;
          acc_wr = 1'b1;
        end
        OP_MSUB: begin
          acc_new = acc_cur - mul_s;
          acc_wr = 1'b1;
        end
        OP_MSUBU: begin
          acc_new = acc_cur - mul_u;
          acc_wr = 1'b1;
        end
        // reversed low half, upper half cleared
        OP_BIT_REV: begin
          gpr = 32'h00000000;
          for (int i = 0; i < 16; i++) begin
            gpr[i] = opb_q[15-i];
          end
          gpr_wr = 1'b1;
        end
        // field insert into second operand; bits past 31 are dropped
        OP_FIELD_INS: begin
          gpr = (opb_q & ~fmask[31:0]) | ((opa_q << fpos) & fmask[31:0]);
          gpr_wr = 1'b1;
        end
        OP_REPB_IMM: begin gpr = {4{imm10[7:0]}}; gpr_wr = 1'b1; end
        OP_REPB_REG: begin gpr = {4{opb_q[7:0]}}; gpr_wr = 1'b1; end
        OP_REPH_IMM: begin gpr = {2{{6{imm10[9]}}, imm10}}; gpr_wr = 1'b1; end
        OP_REPH_REG: begin gpr = {2{opb_q[15:0]}}; gpr_wr = 1'b1; end
        // unsigned byte compare to condition bits
        OP_CMPB_EQ, OP_CMPB_LT, OP_CMPB_LE: begin
          for (int i = 0; i < 4; i++) begin
            ctrl_d[`DSPM_CCOND_LSB + i] = (op == OP_CMPB_EQ) ? opa_q[8*i +: 8] == opb_q[8*i +: 8] :
              (op == OP_CMPB_LT) ? opa_q[8*i +: 8] < opb_q[8*i +: 8] :
              opa_q[8*i +: 8] <= opb_q[8*i +: 8];
          end
        end
        // unsigned byte compare to result word
        OP_CMPG_EQ, OP_CMPG_LT, OP_CMPG_LE: begin
          gpr = 32'h00000000;
          for (int i = 0; i < 4; i++) begin
            gpr[i] = (op == OP_CMPG_EQ) ? opa_q[8*i +: 8] == opb_q[8*i +: 8] :
              (op == OP_CMPG_LT) ? opa_q[8*i +: 8] < opb_q[8*i +: 8] :
              opa_q[8*i +: 8] <= opb_q[8*i +: 8];
          end
          gpr_wr = 1'b1;
        end
        // signed halfword compare, upper condition bits kept
        OP_CMPH_EQ, OP_CMPH_LT, OP_CMPH_LE: begin
          for (int i = 0; i < 2; i++) begin
            ctrl_d[`DSPM_CCOND_LSB + i] = (op == OP_CMPH_EQ) ?
              opa_q[16*i +: 16] == opb_q[16*i +: 16] : (op == OP_CMPH_LT) ?
              $signed(opa_q[16*i +: 16]) < $signed(opb_q[16*i +: 16]) :
              $signed(opa_q[16*i +: 16]) <= $signed(opb_q[16*i +: 16]);
          end
        end
        OP_SELB: begin
          for (int i = 0; i < 4; i++) begin
            gpr[8*i +: 8] = ccond[i] ? opa_q[8*i +: 8] : opb_q[8*i +: 8];
          end
          gpr_wr = 1'b1;
        end
        OP_SELH: begin
          for (int i = 0; i < 2; i++) begin
            gpr[16*i +: 16] = ccond[i] ? opa_q[16*i +: 16] : opb_q[16*i +: 16];
          end
          gpr_wr = 1'b1;
        end
        OP_PACK: begin gpr = {opa_q[15:0], opb_q[31:16]}; gpr_wr = 1'b1; end
        // word extract, plain, rounded, rounded with clamp
        OP_XW: begin gpr = xt[32:1]; gpr_wr = 1'b1; end
        OP_XW_RND: begin gpr = xr[32:1]; gpr_wr = 1'b1; end
        OP_XW_RSAT: begin
          gpr = (!xt[32] && xr[32]) ? 32'h7FFFFFFF : xr[32:1];
          gpr_wr = 1'b1;
        end
        OP_XH_SAT: begin
          if ($signed(xs) > $signed(64'h0000000000007FFF)) begin
            gpr = 32'h00007FFF;
          end else if ($signed(xs) < $signed(64'hFFFFFFFFFFFF8000)) begin
            gpr = 32'hFFFF8000;
          end else begin
            gpr = {{16{xs[15]}}, xs[15:0]};
          end
          gpr_wr = 1'b1;
        end
        default: begin
          gpr_wr = 1'b0;
        end
      endcase
    end
    // Register write and response
    if (wr_fire) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `DSPM_RESP_OKAY;
      if (awaddr_q[7:5] == `DSPM_ACC_BASE_HI) begin
        if (awaddr_q[2]) begin
          acc_hi_d[awaddr_q[4:3]] = apply_strb(acc_hi_q[awaddr_q[4:3]], wdata_q, wstrb_q);
        end else begin
          acc_lo_d[awaddr_q[4:3]] = apply_strb(acc_lo_q[awaddr_q[4:3]], wdata_q, wstrb_q);
        end
      end else begin
        case (awaddr_q)
          `DSPM_OFF_OPA: opa_d = apply_strb(opa_q, wdata_q, wstrb_q);
          `DSPM_OFF_OPB: opb_d = apply_strb(opb_q, wdata_q, wstrb_q);
          `DSPM_OFF_CTRL: ctrl_d = apply_strb(ctrl_q, wdata_q, wstrb_q) & `DSPM_CTRL_MASK;
          `DSPM_OFF_CMD: bresp_d = `DSPM_RESP_OKAY;
          default: bresp_d = `DSPM_RESP_SLVERR;
        endcase
      end
    end
    if (gpr_wr) begin
      result_d = gpr;
    end
    if (acc_wr) begin
      acc_hi_d[acc_sel] = acc_new[63:32];
      acc_lo_d[acc_sel] = acc_new[31:0];
    end
    // Read channel; unmapped reads give zero with an error
    if (rvalid_q && S_AXI_RREADY_I) begin
      rvalid_d = 1'b0;
    end
    if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      rvalid_d = 1'b1;
      rresp_d = `DSPM_RESP_OKAY;
      rdata_d = 32'h00000000;
      if (S_AXI_ARADDR_I[7:5] == `DSPM_ACC_BASE_HI) begin
        rdata_d = S_AXI_ARADDR_I[2] ? acc_hi_q[S_AXI_ARADDR_I[4:3]] :
          acc_lo_q[S_AXI_ARADDR_I[4:3]];
      end else begin
        case (S_AXI_ARADDR_I)
          `DSPM_OFF_OPA: rdata_d = opa_q;
          `DSPM_OFF_OPB: rdata_d = opb_q;
          `DSPM_OFF_CTRL: rdata_d = ctrl_q;
          `DSPM_OFF_RESULT: rdata_d = result_q;
          default: rresp_d = `DSPM_RESP_SLVERR;
        endcase
      end
    end
  end

  // State registers, frozen while the enable is low
  always_ff @(posedge MCLK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      opa_q <= 32'h00000000;
      opb_q <= 32'h00000000;
      ctrl_q <= `DSPM_CTRL_RST;
      result_q <= 32'h00000000;
      acc_hi_q <= '{default: 32'h00000000};
      acc_lo_q <= '{default: 32'h00000000};
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
    end else if (CE_I) begin
      opa_q <= opa_d;
      opb_q <= opb_d;
      ctrl_q <= ctrl_d;
      result_q <= result_d;
      acc_hi_q <= acc_hi_d;
      acc_lo_q <= acc_lo_d;
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Checks on the datapath results and on the write response
  default clocking dspm_cb @(posedge MCLK_I); endclocking
  default disable iff (!rst_n_q);

  dot_clamp_a: assert property (exec && op == OP_DOT_ADD && opa_q == 32'h80008000 &&
    opb_q == 32'h80008000 && acc_cur == 64'h0 |=> acc_lo_q[$past(acc_sel)] == 32'hFFFFFFFE &&
    acc_hi_q[$past(acc_sel)] == 32'h0) else $error("dot add clamp wrong");
  mac_sat_range_a: assert property (exec && (op == OP_MAC_SAT_L || op == OP_MAC_SAT_R)
    |=> acc_hi_q[$past(acc_sel)] == {32{acc_lo_q[$past(acc_sel)][31]}})
    else $error("saturating MAC left Q31 range");
  mult_other_acc_a: assert property (exec && op == OP_MULT |=>
    acc_hi_q[$past(acc_sel) + 2'h1] == $past(acc_hi_q[acc_sel + 2'h1]))
    else $error("multiply touched another accumulator");
  bit_rev_a: assert property (exec && op == OP_BIT_REV |=> result_q[31:16] == 16'h0 &&
    result_q[0] == $past(opb_q[15]) && result_q[15] == $past(opb_q[0]))
    else $error("bit reverse wrong");
  ins_zero_a: assert property (exec && op == OP_FIELD_INS && fsize == 5'h0
    |=> result_q == $past(opb_q)) else $error("empty insert changed value");
  rep_byte_a: assert property (exec && op == OP_REPB_REG |=>
    result_q == {4{$past(opb_q[7:0])}}) else $error("byte replicate wrong");
  cmpg_upper_a: assert property (exec && op == OP_CMPG_EQ |=> result_q[31:4] == 28'h0 &&
    result_q[0] == ($past(opa_q[7:0]) == $past(opb_q[7:0]))) else $error("compare result wrong");
  sel_byte_a: assert property (exec && op == OP_SELB ##1 CE_I |=>
    $past(result_q[7:0]) == $past(ccond[0] ? opa_q[7:0] : opb_q[7:0], 2))
    else $error("byte select wrong");
  half_sat_a: assert property (exec && op == OP_XH_SAT |=>
    result_q[31:15] == {17{result_q[15]}}) else $error("half extract out of range");
  bresp_hold_a: assert property (bvalid_q && !S_AXI_BREADY_I |=> bvalid_q)
    else $error("write response dropped");

  q31_add_c: cover property (exec && op == OP_Q31_ADD);
  rsat_clamp_c: cover property (exec && op == OP_XW_RSAT && !xt[32] && xr[32]);
  read_done_c: cover property (rvalid_q && S_AXI_RREADY_I);
  mac_sat_c: cover property (exec && op == OP_MAC_SAT_L ##1 acc_lo_q[0] == 32'h7FFFFFFF);
endmodule

// ===== sim/tb_dsp_fractional_mac_datapath.sv
// Self-checking bench for the fractional MAC datapath over AXI4-Lite
`timescale 1ns/1ns
module tb_dsp_fractional_mac_datapath;
  import dspm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  dspm_word_t wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b0, rready = 1'b0, ce = 1'b1;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int num_errors = 0, checks = 0;
  // Response readys rise only once an answer is seen, so a held answer is exercised
  dspm_datapath dut (
    .MCLK_I(clk), .NRST_I(nrst), .CE_I(ce),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready)
  );
  initial begin
    forever #4 clk = ~clk;
  end
  // Readys judged at the falling edge, so the rising edge takes them cleanly
  task automatic wr(input logic [7:0] a, input dspm_word_t d, output logic [1:0] r);
    logic ah, dh;
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid} <= 2'h3;
    {ah, dh} = 2'h0;
    while (!(ah && dh)) begin
      @(negedge clk);
      {ah, dh} = {ah | (awvalid & awready), dh | (wvalid & wready)};
      @(posedge clk);
      {awvalid, wvalid} <= {awvalid & ~ah, wvalid & ~dh};
    end
    // Answer seen; raise the ready at the next rising edge, taken at the one after
    do @(negedge clk); while (!bvalid);
    @(posedge clk);
    bready <= 1'b1;
    @(negedge clk);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output dspm_word_t d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    @(posedge clk);
    rready <= 1'b1;
    @(negedge clk);
    {d, r} = {rdata, rresp};
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Command word: immediate or shift in 25:16, accumulator in 9:8, code in 5:0
  task automatic cmd(input dspm_op_e op, input logic [1:0] n, input logic [9:0] g);
    logic [1:0] r;
    wr(8'h0C, {6'h00, g, 6'h00, n, 2'h0, op}, r);
  endtask
  task automatic ops(input dspm_word_t a, input dspm_word_t b);
    logic [1:0] r;
    wr(8'h00, a, r);
    wr(8'h04, b, r);
  endtask
  task automatic opr(input dspm_op_e op, input logic [9:0] g, input dspm_word_t e);
    dspm_word_t d;
    logic [1:0] r;
    cmd(op, 2'h0, g);
    rd(8'h10, d, r);
    chk(d, e);
  endtask
  task automatic accq(input logic [1:0] n, input dspm_acc_t e);
    dspm_word_t lo, hi;
    logic [1:0] r;
    rd(8'h20 + {3'h0, n, 3'h0}, lo, r);
    rd(8'h24 + {3'h0, n, 3'h0}, hi, r);
    chk({hi, lo}, e);
  endtask
  task automatic acx(input dspm_op_e op, input logic [1:0] n, input dspm_acc_t e);
    cmd(op, n, 10'h000);
    accq(n, e);
  endtask
  // reset values, map edges, read-only result
  task automatic t_map;
    dspm_word_t d;
    logic [1:0] r;
    rd(8'h08, d, r);
    chk({d, r}, {32'h0, 2'h0});
    accq(2'h3, 64'h0);
    rd(8'h40, d, r);
    chk({d, r}, {32'h0, 2'h2});
    wr(8'h10, 32'hFFFFFFFF, r);
    chk(r, 2'h2);
    // Byte strobes merge into the held word
    wstrb <= 4'h2;
    wr(8'h00, 32'hFFFFFFFF, r);
    wstrb <= 4'hF;
    chk(r, 2'h0);
    rd(8'h00, d, r);
    chk({d, r}, {32'h0000FF00, 2'h0});
    // Enable low drops the address, data and read readys
    ce <= 1'b0;
    repeat (2) @(negedge clk);
    chk({awready, wready, arready}, 3'h0);
    @(posedge clk);
    ce <= 1'b1;
  endtask
  // fractional products, -1.0 squared and overflow
  task automatic t_frac;
    ops(32'h80008000, 32'h80008000);
    acx(OP_DOT_ADD, 2'h1, 64'hFFFFFFFE);
    acx(OP_DOT_SUB, 2'h1, 64'h0);
    ops(32'h80000002, 32'h80000003);
    acx(OP_CPLX_STEP, 2'h1, 64'h7FFFFFF3);
    acx(OP_MAC_L, 2'h3, 64'h7FFFFFFF);
    acx(OP_MAC_R, 2'h3, 64'h8000000B);
    acx(OP_MAC_SAT_R, 2'h0, 64'hC);
    acx(OP_MAC_SAT_L, 2'h0, 64'h7FFFFFFF);
    ops(32'h80000000, 32'h80000000);
    acx(OP_Q31_ADD, 2'h2, 64'h7FFFFFFFFFFFFFFF);
    acx(OP_Q31_ADD, 2'h2, 64'h7FFFFFFFFFFFFFFF);
    acx(OP_Q31_SUB, 2'h2, 64'h0);
  endtask
  task automatic t_int;
    ops(32'h00000003, 32'hFFFFFFFB);
    acx(OP_MULT, 2'h2, 64'hFFFFFFFFFFFFFFF1);
    acx(OP_MADDU, 2'h2, 64'h2FFFFFFE2);
    acx(OP_MSUB, 2'h3, 64'h8000001A);
    acx(OP_MULTU, 2'h1, 64'h2FFFFFFF1);
    acx(OP_MSUBU, 2'h1, 64'h0);
    acx(OP_MADD, 2'h0, 64'h7FFFFFF0);
  endtask
  task automatic t_bits;
    logic [1:0] r;
    ops(32'hFFFF0001, 32'hFFFF0001);
    opr(OP_BIT_REV, 10'h000, 32'h00008000);
    opr(OP_REPB_REG, 10'h000, 32'h01010101);
    opr(OP_REPB_IMM, 10'h3A5, 32'hA5A5A5A5);
    opr(OP_REPH_REG, 10'h000, 32'h00010001);
    opr(OP_REPH_IMM, 10'h200, 32'hFE00FE00);
    wr(8'h08, 32'h00081000, r);
    ops(32'h0000000A, 32'hFFFFFFFF);
    opr(OP_FIELD_INS, 10'h000, 32'hFFFFFAFF);
  endtask
  // lane compares and selects; codes are consecutive
  task automatic t_cmp;
    logic [3:0] cb[3] = '{4'h8, 4'h5, 4'hD};
    logic [3:0] ch[3] = '{4'hD, 4'hE, 4'hF};
    dspm_word_t d;
    logic [1:0] r;
    ops(32'h01020304, 32'h01FF0005);
    for (int i = 0; i < 3; i++) begin
      cmd(dspm_op_e'(OP_CMPB_EQ + i), 2'h0, 10'h000);
      rd(8'h08, d, r);
      chk(d, {4'h0, cb[i], 24'h081000});
      opr(dspm_op_e'(OP_CMPG_EQ + i), 10'h000, {28'h0, cb[i]});
    end
    // Upper condition bits must survive the halfword compares
    ops(32'h80000005, 32'h00010005);
    for (int i = 2; i >= 0; i--) begin
      cmd(dspm_op_e'(OP_CMPH_EQ + i), 2'h0, 10'h000);
      rd(8'h08, d, r);
      chk(d, {4'h0, ch[i], 24'h081000});
    end
    ops(32'h11112222, 32'h33334444);
    opr(OP_SELH, 10'h000, 32'h33332222);
    opr(OP_SELB, 10'h000, 32'h11114422);
    opr(OP_PACK, 10'h000, 32'h22223333);
  endtask
  // extraction with rounding overflow and clamps
  task automatic t_ext;
    logic [1:0] r;
    wr(8'h20, 32'hFFFFFFFF, r);
    wr(8'h24, 32'h0, r);
    opr(OP_XW, 10'h001, 32'h7FFFFFFF);
    opr(OP_XW_RND, 10'h001, 32'h80000000);
    opr(OP_XW_RSAT, 10'h001, 32'h7FFFFFFF);
    opr(OP_XH_SAT, 10'h001, 32'h00007FFF);
    wr(8'h20, 32'h80000000, r);
    wr(8'h24, 32'hFFFFFFFF, r);
    opr(OP_XW, 10'h000, 32'h80000000);
    opr(OP_XH_SAT, 10'h000, 32'hFFFF8000);
  endtask
  task automatic summarize;
    $display("Checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_map();
    t_frac();
    t_int();
    t_bits();
    t_cmp();
    t_ext();
    summarize();
  end
  // Watchdog, far beyond the several hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
endmodule
